// *** common/car_pkg.sv ***
/*
 package for the concentration alarm relay block: widths, reset values,
 command codes and port structs. assumes one system clock and sync reset.
*/
package car_pkg;
    localparam int CONC_W = 16;
    localparam int SCALE_W = 8;
    localparam int NUM_GAS = 2;
    localparam int CMD_W = 4;
    // scaling factor is fixed point with this many fraction bits
    localparam int SCALE_FRAC = 4;
    localparam logic [SCALE_W-1:0] SCALE_ONE = 8'h10;
    localparam logic RELAY_RESET = 1'b0;
    localparam logic WARN_RESET = 1'b0;

    // remote command codes
    typedef enum logic [3:0] {
        CAR_CMD_NONE = 4'h0,
        CAR_CMD_DATA_REQ = 4'h1,
        CAR_CMD_CAL = 4'h2,
        CAR_CMD_DIAGNOSTIC = 4'h3,
        CAR_CMD_RESET = 4'h4,
        CAR_CMD_CLEAR_WARN = 4'h5
    } car_cmd_t;

    typedef struct packed {
        logic [CONC_W-1:0] level1;
        logic [CONC_W-1:0] level2;
        logic enable1;
        logic enable2;
    } car_gas_cfg_t;

    typedef struct packed {
        logic valid;
        car_cmd_t code;
    } car_cmd_req_t;

    typedef struct packed {
        logic health_relay;
        logic conc1_relay;
        logic conc2_relay;
        logic range_relay;
    } car_relays_t;
endpackage

// *** rtl/car_scale.sv ***
/*
 dilution scaler: multiplies a value by a fixed point factor when enabled.
 assumes factor uses SCALE_FRAC fraction bits; result saturates.
*/
module car_scale #(
    parameter int W = car_pkg::CONC_W,
    parameter int SW = car_pkg::SCALE_W
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic enable,
    input wire logic [SW-1:0] factor,
    input wire logic [W-1:0] raw,
    output logic [W-1:0] scaled
);
    import car_pkg::*;

    initial begin
        if (SW <= SCALE_FRAC) begin
            $error("scale width too small");
        end
    end

    typedef struct packed {
        logic [W-1:0] scaled;
    } car_scale_state_t;

    car_scale_state_t state;
    car_scale_state_t next_state;
    logic [W+SW-1:0] product;
    logic [W+SW-1:0] shifted;

    always_comb begin
        next_state = state;
        product = raw * factor;
        shifted = product >> SCALE_FRAC;
        // multiply by dilution factor
        if (!enable) begin
            next_state.scaled = raw;
        end else if (|shifted[W+SW-1:W]) begin
            next_state.scaled = {W{1'b1}};
        end else begin
            next_state.scaled = shifted[W-1:0];
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign scaled = state.scaled;

    a_scale_pass: assert property (@(posedge clock) disable iff (!rst_n)
        !enable |=> scaled == $past(raw))
        else $error("unscaled value not passed through");
endmodule

// *** rtl/car_relay_ctrl.sv ***
/*
 concentration alarm relay control: four relay drives, latched front panel
 warnings, maintenance command gate and dilution scaling of results.
 assumes all inputs synchronous to clock; concentrations are unscaled.
*/
module car_relay_ctrl #(
    parameter int N_GAS = car_pkg::NUM_GAS
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic instrument_ok,
    input wire logic [7:0] other_warnings,
    input wire logic diagnostic_mode,
    input wire logic [N_GAS*car_pkg::CONC_W-1:0] conc_raw,
    input wire logic conc_valid,
    input wire car_pkg::car_gas_cfg_t [N_GAS-1:0] gas_cfg,
    input wire logic auto_range,
    input wire logic high_range,
    input wire logic [car_pkg::CONC_W-1:0] range_raw,
    input wire logic dilution_enable,
    input wire logic [car_pkg::SCALE_W-1:0] dilution_factor,
    input wire logic warning_clear_key,
    input wire logic maintenance_switch,
    input wire car_pkg::car_cmd_req_t remote_command_port,
    output car_pkg::car_relays_t relays,
    output logic health_nc_closed,
    output logic [2*N_GAS-1:0] conc_warning,
    output logic [N_GAS*car_pkg::CONC_W-1:0] conc_report,
    output logic [car_pkg::CONC_W-1:0] range_report,
    output car_pkg::car_cmd_req_t command_out,
    output logic data_request,
    output logic command_dropped
);
    import car_pkg::*;

    initial begin
        if (N_GAS < 1 || N_GAS > 8) begin
            $error("gas count out of range");
        end
        if (SCALE_FRAC >= SCALE_W) begin
            $error("dilution factor has no integer bits");
        end
    end

    typedef struct packed {
        car_relays_t relays;
        logic health_nc_closed;
        logic [2*N_GAS-1:0] warn;
        car_cmd_req_t cmd;
        logic data_request;
        logic command_dropped;
    } car_state_t;

    car_state_t state;
    car_state_t next_state;
    logic [N_GAS*CONC_W-1:0] conc_scaled;
    logic [2*N_GAS-1:0] above;
    logic any_warning;
    logic alters_state;
    logic clear_cmd;
    logic clear_now;
    logic [N_GAS-1:0] lvl1_seen;
    logic [N_GAS-1:0] lvl2_seen;
    logic [2*N_GAS-1:0] lvl_off;

    // per gas scaling and level comparison
    genvar g;
    generate
        for (g = 0; g < N_GAS; g++) begin : gen_gas
            car_scale u_scale (
                .clock(clock),
                .rst_n(rst_n),
                .enable(dilution_enable),
                .factor(dilution_factor),
                .raw(conc_raw[g*CONC_W +: CONC_W]),
                .scaled(conc_scaled[g*CONC_W +: CONC_W])
            );
            // each gas has two levels, each disableable
            assign above[2*g] = gas_cfg[g].enable1 &&
                (conc_scaled[g*CONC_W +: CONC_W] > gas_cfg[g].level1);
            assign above[2*g+1] = gas_cfg[g].enable2 &&
                (conc_scaled[g*CONC_W +: CONC_W] > gas_cfg[g].level2);
            // level sums and disabled levels watched by the checks below
            assign lvl1_seen[g] = above[2*g];
            assign lvl2_seen[g] = above[2*g+1];
            assign lvl_off[2*g] = !gas_cfg[g].enable1;
            assign lvl_off[2*g+1] = !gas_cfg[g].enable2;
        end
    endgenerate

    car_scale u_range_scale (
        .clock(clock),
        .rst_n(rst_n),
        .enable(dilution_enable),
        .factor(dilution_factor),
        .raw(range_raw),
        .scaled(range_report)
    );

    assign conc_report = conc_scaled;

    // remote command decoding
    always_comb begin
        alters_state = 1'b0;
        clear_cmd = 1'b0;
        case (remote_command_port.code)
            CAR_CMD_CAL, CAR_CMD_DIAGNOSTIC, CAR_CMD_RESET: begin
                alters_state = 1'b1;
            end
            CAR_CMD_CLEAR_WARN: begin
                clear_cmd = 1'b1;
            end
            default: begin
                alters_state = 1'b0;
            end
        endcase
    end

    assign clear_now = warning_clear_key || (remote_command_port.valid && clear_cmd);
    assign any_warning = (|state.warn) || (|other_warnings);

    always_comb begin
        logic [N_GAS-1:0] lvl1;
        logic [N_GAS-1:0] lvl2;
        lvl1 = '0;
        lvl2 = '0;
        next_state = state;
        for (int i = 0; i < N_GAS; i++) begin
            lvl1[i] = above[2*i];
            lvl2[i] = above[2*i+1];
        end
        // level one of all gases ORed onto relay one
        next_state.relays.conc1_relay = conc_valid ? (|lvl1) : state.relays.conc1_relay;
        // second set point, same non-latching behaviour
        next_state.relays.conc2_relay = conc_valid ? (|lvl2) : state.relays.conc2_relay;
        // latched warnings, a new event wins over clear
        if (clear_now) begin
            next_state.warn = '0;
        end
        if (conc_valid) begin
            next_state.warn = next_state.warn | above;
        end
        // health relay
        next_state.relays.health_relay = instrument_ok && !any_warning && !diagnostic_mode;
        // inverted contact: nc path closed when de-energized
        next_state.health_nc_closed = !next_state.relays.health_relay;
        // range bit relay
        next_state.relays.range_relay = auto_range && high_range;
        // maintenance gate
        next_state.cmd = '0;
        next_state.data_request = 1'b0;
        next_state.command_dropped = 1'b0;
        if (remote_command_port.valid) begin
            if (maintenance_switch && alters_state) begin
                next_state.command_dropped = 1'b1;
            end else if (remote_command_port.code == CAR_CMD_DATA_REQ) begin
                next_state.data_request = 1'b1;
            end else begin
                next_state.cmd = remote_command_port;
            end
        end
    end

    // all relays from flip-flops
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state.relays <= '{RELAY_RESET, RELAY_RESET, RELAY_RESET, RELAY_RESET};
            state.health_nc_closed <= 1'b1;
            state.warn <= {2*N_GAS{WARN_RESET}};
            state.cmd <= '0;
            state.data_request <= 1'b0;
            state.command_dropped <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    assign relays = state.relays;
    assign health_nc_closed = state.health_nc_closed;
    assign conc_warning = state.warn;
    assign command_out = state.cmd;
    assign data_request = state.data_request;
    assign command_dropped = state.command_dropped;

    a_health_drop: assert property (@(posedge clock) disable iff (!rst_n)
        (diagnostic_mode || !instrument_ok || (|other_warnings)) |=> !relays.health_relay)
        else $error("health relay held during fault");

    a_health_on: assert property (@(posedge clock) disable iff (!rst_n)
        (instrument_ok && !diagnostic_mode && !(|other_warnings) && !(|conc_warning))
        |=> relays.health_relay)
        else $error("health relay not energized");

    a_health_warn: assert property (@(posedge clock) disable iff (!rst_n)
        (|conc_warning) |=> !relays.health_relay)
        else $error("health relay held with latched warning");

    a_ok_contact: assert property (@(posedge clock) disable iff (!rst_n)
        !instrument_ok |=> health_nc_closed)
        else $error("contact path open while not ok");

    a_health_inv: assert property (@(posedge clock) disable iff (!rst_n)
        health_nc_closed == !relays.health_relay)
        else $error("health contact sense wrong");

    a_diagnostic_mode_contact: assert property (@(posedge clock) disable iff (!rst_n)
        diagnostic_mode |=> health_nc_closed)
        else $error("contact path open in diagnostic mode");

    a_conc1_follow: assert property (@(posedge clock) disable iff (!rst_n)
        conc_valid |=> relays.conc1_relay == $past(|lvl1_seen))
        else $error("conc relay one mismatch");

    a_conc2_follow: assert property (@(posedge clock) disable iff (!rst_n)
        conc_valid |=> relays.conc2_relay == $past(|lvl2_seen))
        else $error("conc relay two mismatch");

    a_conc_hold: assert property (@(posedge clock) disable iff (!rst_n)
        !conc_valid |=> $stable(relays.conc1_relay) && $stable(relays.conc2_relay))
        else $error("conc relay moved without fresh result");

    a_warn_set: assert property (@(posedge clock) disable iff (!rst_n)
        conc_valid |=> (conc_warning & $past(above)) == $past(above))
        else $error("warning not set by alarm");

    a_warn_latch: assert property (@(posedge clock) disable iff (!rst_n)
        (conc_warning[0] && !clear_now) |=> conc_warning[0])
        else $error("warning lost without clear");

    a_warn_hold: assert property (@(posedge clock) disable iff (!rst_n)
        !clear_now |=> (conc_warning & $past(conc_warning)) == $past(conc_warning))
        else $error("latched warning dropped without clear");

    a_warn_clear: assert property (@(posedge clock) disable iff (!rst_n)
        (clear_now && !conc_valid) |=> conc_warning == '0)
        else $error("warning not cleared");

    a_disabled_lvl: assert property (@(posedge clock) disable iff (!rst_n)
        (!gas_cfg[0].enable1 && !(conc_warning[0])) |=> !conc_warning[0]
        || $past(gas_cfg[0].enable1) != gas_cfg[0].enable1)
        else $error("disabled level set warning");

    a_disabled_src: assert property (@(posedge clock) disable iff (!rst_n)
        (above & lvl_off) == '0)
        else $error("disabled level compared as alarm");

    a_range_relay: assert property (@(posedge clock) disable iff (!rst_n)
        (auto_range && high_range) |=> relays.range_relay)
        else $error("range relay not energized");

    a_range_off: assert property (@(posedge clock) disable iff (!rst_n)
        !(auto_range && high_range) |=> !relays.range_relay)
        else $error("range relay on outside auto high range");

    a_conc_report: assert property (@(posedge clock) disable iff (!rst_n)
        !dilution_enable |=> conc_report == $past(conc_raw))
        else $error("unscaled concentration not reported");

    a_range_report: assert property (@(posedge clock) disable iff (!rst_n)
        !dilution_enable |=> range_report == $past(range_raw))
        else $error("unscaled range not reported");

    a_maint_gate: assert property (@(posedge clock) disable iff (!rst_n)
        (maintenance_switch && remote_command_port.valid && alters_state)
        |=> command_dropped && !command_out.valid)
        else $error("state command passed in maintenance");

    a_cmd_pass: assert property (@(posedge clock) disable iff (!rst_n)
        (remote_command_port.valid && !maintenance_switch
        && remote_command_port.code != CAR_CMD_DATA_REQ)
        |=> command_out == $past(remote_command_port))
        else $error("accepted command not passed on");

    a_cmd_idle: assert property (@(posedge clock) disable iff (!rst_n)
        !remote_command_port.valid |=> !command_out.valid && !data_request && !command_dropped)
        else $error("command pulse without request");

    a_drop_only: assert property (@(posedge clock) disable iff (!rst_n)
        command_dropped |-> $past(maintenance_switch))
        else $error("command dropped outside maintenance");

    a_maint_data: assert property (@(posedge clock) disable iff (!rst_n)
        (remote_command_port.valid && remote_command_port.code == CAR_CMD_DATA_REQ)
        |=> data_request && !command_dropped)
        else $error("data request not answered");

    a_data_only: assert property (@(posedge clock) disable iff (!rst_n)
        data_request |-> $past(remote_command_port.valid)
        && $past(remote_command_port.code) == CAR_CMD_DATA_REQ)
        else $error("data request without request");

    c_conc1: cover property (@(posedge clock) disable iff (!rst_n) relays.conc1_relay);
    c_conc2: cover property (@(posedge clock) disable iff (!rst_n) relays.conc2_relay);
    c_drop: cover property (@(posedge clock) disable iff (!rst_n) command_dropped);
    c_range: cover property (@(posedge clock) disable iff (!rst_n) relays.range_relay);
    c_clear: cover property (@(posedge clock) disable iff (!rst_n)
        conc_warning[0] ##1 !conc_warning[0]);
endmodule

// *** sim/car_logger.sv ***
/*
 data logger model at the rear panel: counts how often the health
 contact path closes (fault shown). assumes relay outputs settle on clock.
*/
module car_logger (
    input wire logic clock,
    input wire logic rst_n,
    input wire car_pkg::car_relays_t relays,
    input wire logic health_nc_closed,
    output int unsigned fault_marks,
    output int unsigned alarm_marks
);
    timeunit 1ns;
    timeprecision 1ps;
    import car_pkg::*;
    logic last_nc = 1'b1;
    logic last_alarm = 1'b0;
    int unsigned faults = 0;
    int unsigned alarms = 0;
    // logger only records contact changes; it never drives the block
    always @(posedge clock) begin
        if (rst_n && health_nc_closed && !last_nc) begin
            faults <= faults + 1;
        end
        if (rst_n && relays.conc1_relay && !last_alarm) begin
            alarms <= alarms + 1;
        end
        last_nc <= health_nc_closed;
        last_alarm <= relays.conc1_relay;
    end
    assign fault_marks = faults;
    assign alarm_marks = alarms;
endmodule

// *** sim/concentration_alarm_relay_control_test.sv ***
/*
 self-checking bench for the relay control block with a logger model.
 assumes two gases, 4 ns clock, inputs driven on the falling edge.
*/
module concentration_alarm_relay_control_test;
    timeunit 1ns;
    timeprecision 1ps;
    import car_pkg::*;
    typedef struct {
        logic [15:0] c0;
        logic [15:0] c1;
        logic en;
        logic [7:0] f;
        logic r1;
        logic r2;
        logic [3:0] w;
    } car_row_t;
    logic clock = 1'b0, rst_n = 1'b0, instrument_ok = 1'b1, diagnostic_mode = 1'b0;
    logic conc_valid = 1'b0, auto_range = 1'b0, high_range = 1'b0, dilution_enable = 1'b0;
    logic warning_clear_key = 1'b0, maintenance_switch = 1'b0;
    logic [7:0] other_warnings = 8'h00, dilution_factor = 8'h10;
    logic [31:0] conc_raw = 32'h0, conc_report;
    logic [15:0] range_raw = 16'h0, range_report;
    car_gas_cfg_t [1:0] gas_cfg = '{'{16'h0200, 16'h0800, 1'b1, 1'b1},
        '{16'h0100, 16'h0400, 1'b1, 1'b1}};
    car_cmd_req_t remote_command_port = '0, command_out;
    car_relays_t relays;
    logic health_nc_closed, data_request, command_dropped;
    logic [3:0] conc_warning;
    int unsigned fault_marks, alarm_marks, m;
    int fail_count = 0, n_checks = 0, cycles = 0;
    car_row_t rows[5] = '{'{16'h0100, 16'h0, 0, 8'h10, 0, 0, 4'h0},
        '{16'h0101, 16'h0, 0, 8'h10, 1, 0, 4'h1}, '{16'h0, 16'h0801, 0, 8'h10, 1, 1, 4'hC},
        '{16'h0080, 16'h0, 1, 8'h40, 1, 0, 4'h1}, '{16'h8000, 16'h0, 1, 8'h20, 1, 1, 4'h3}};

    car_relay_ctrl DUT (.clock(clock), .rst_n(rst_n), .instrument_ok(instrument_ok),
        .other_warnings(other_warnings), .diagnostic_mode(diagnostic_mode),
        .conc_raw(conc_raw), .conc_valid(conc_valid), .gas_cfg(gas_cfg),
        .auto_range(auto_range), .high_range(high_range), .range_raw(range_raw),
        .dilution_enable(dilution_enable), .dilution_factor(dilution_factor),
        .warning_clear_key(warning_clear_key), .maintenance_switch(maintenance_switch),
        .remote_command_port(remote_command_port), .relays(relays),
        .health_nc_closed(health_nc_closed), .conc_warning(conc_warning),
        .conc_report(conc_report), .range_report(range_report), .command_out(command_out),
        .data_request(data_request), .command_dropped(command_dropped));
    car_logger logger (.clock(clock), .rst_n(rst_n), .relays(relays),
        .health_nc_closed(health_nc_closed), .fault_marks(fault_marks),
        .alarm_marks(alarm_marks));

    always #2 clock = ~clock;
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            end_of_test();
        end
    end

    function automatic logic [15:0] scl(input logic [15:0] r, input logic en,
        input logic [7:0] f);
        logic [23:0] p;
        p = (24'(r) * 24'(f)) >> 4;
        if (!en) return r;
        return (p > 24'h00FFFF) ? 16'hFFFF : p[15:0];
    endfunction
    task automatic step(input int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        n_checks++;
        if (got !== exp) begin
            $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
            fail_count++;
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        step(6);
        chk(relays, 4'h0, "relays in reset");
        chk(health_nc_closed, 1, "nc in reset");
        chk(conc_warning, 4'h0, "warnings in reset");
        chk(conc_report, 32'h0, "report in reset");
        chk({command_out, data_request, command_dropped}, 7'h00, "pulses in reset");
        rst_n = 1'b1;
        step(2);
        chk(relays.health_relay, 1, "health ok");
        chk(health_nc_closed, 0, "nc open when ok");
        $display("test reset done");
        conc_valid = 1'b1;
        for (int i = 0; i < 5; i++) begin
            conc_raw = {rows[i].c1, rows[i].c0};
            dilution_enable = rows[i].en;
            dilution_factor = rows[i].f;
            step(4);
            chk(conc_report[15:0], scl(rows[i].c0, rows[i].en, rows[i].f), "report");
            chk(conc_report[31:16], scl(rows[i].c1, rows[i].en, rows[i].f), "rep2");
            chk(relays.conc1_relay, rows[i].r1, "conc1");
            chk(relays.conc2_relay, rows[i].r2, "conc2");
            chk(conc_warning, rows[i].w, "warnings");
            chk(relays.health_relay, rows[i].w == 4'h0, "health vs warn");
            conc_raw = 32'h0;
            step(3);
            warning_clear_key = 1'b1;
            step(1);
            warning_clear_key = 1'b0;
            step(2);
            $display("test row %0d done", i);
        end
        dilution_enable = 1'b0;
        m = fault_marks;
        other_warnings = 8'h80;
        step(2);
        chk(relays.health_relay, 0, "health on warning");
        chk(fault_marks, m + 1, "logger saw fault");
        other_warnings = 8'h00;
        diagnostic_mode = 1'b1;
        step(2);
        chk(relays.health_relay, 0, "health in diagnostic_mode");
        diagnostic_mode = 1'b0;
        instrument_ok = 1'b0;
        step(2);
        chk(relays.health_relay, 0, "health not ok");
        instrument_ok = 1'b1;
        $display("test health done");
        m = alarm_marks;
        conc_raw = 32'h0000_0101;
        step(4);
        conc_raw = 32'h0;
        step(4);
        chk(relays.conc1_relay, 0, "conc1 released");
        chk(conc_warning, 4'h1, "warning held");
        chk(relays.health_relay, 0, "health while latched");
        chk(alarm_marks, m + 1, "logger saw alarm");
        remote_command_port = '{1'b1, CAR_CMD_CLEAR_WARN};
        step(1);
        remote_command_port = '0;
        step(2);
        chk(conc_warning, 4'h0, "clear by command");
        conc_raw = 32'h0000_0101;
        step(4);
        warning_clear_key = 1'b1;
        step(1);
        warning_clear_key = 1'b0;
        chk(conc_warning, 4'h1, "set wins over clear");
        gas_cfg[0].enable1 = 1'b0;
        conc_raw = 32'h0000_0300;
        warning_clear_key = 1'b1;
        step(1);
        warning_clear_key = 1'b0;
        step(3);
        chk(relays.conc1_relay, 0, "disabled level");
        chk(conc_warning, 4'h0, "disabled no warn");
        gas_cfg[0].enable1 = 1'b1;
        conc_raw = 32'h0;
        $display("test latch done");
        auto_range = 1'b1;
        high_range = 1'b1;
        range_raw = 16'h1000;
        dilution_enable = 1'b1;
        dilution_factor = 8'h20;
        step(2);
        chk(relays.range_relay, 1, "range high");
        chk(range_report, 16'h2000, "range scaled");
        auto_range = 1'b0;
        step(2);
        chk(relays.range_relay, 0, "manual range");
        dilution_enable = 1'b0;
        $display("test range done");
        for (int ms = 1; ms >= 0; ms--) begin
            maintenance_switch = ms[0];
            for (int c = 1; c < 5; c++) begin
                remote_command_port = '{1'b1, car_cmd_t'(4'(c))};
                step(1);
                chk(data_request, c == 1, "data request");
                chk(command_dropped, ms == 1 && c > 1, "dropped");
                chk(command_out, (ms == 0 && c > 1) ? {1'b1, 4'(c)} : 5'h0, "cmd");
            end
            remote_command_port = '0;
            step(1);
        end
        maintenance_switch = 1'b1;
        conc_raw = 32'h0000_0101;
        step(4);
        chk(relays.conc1_relay, 1, "measures in maint");
        $display("test maintenance done");
        rst_n = 1'b0;
        step(2);
        chk(conc_warning, 4'h0, "warnings after reset");
        chk(relays, 4'h0, "relays after reset");
        chk(health_nc_closed, 1, "nc after reset");
        conc_raw = 32'h0;
        maintenance_switch = 1'b0;
        rst_n = 1'b1;
        step(2);
        chk(relays.health_relay, 1, "health after reset");
        $display("test mid reset done");
        end_of_test();
    end
endmodule
